// *** rtl/ups_port_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ups_defines.svh"

module ups_port_ctrl (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // usb data lines
  input  wire logic        dplus_in,
  input  wire logic        dminus_in,
  output logic             dplus_out,
  output logic             dplus_oe,
  output logic             dminus_out,
  output logic             dminus_oe,
  // engine transmit request
  input  wire logic        engine_drive,
  input  wire logic        engine_dplus,
  input  wire logic        engine_dminus,
  // auxiliary pins
  input  wire logic        regulator_pin_in,
  input  wire logic        crystal_input_pin,
  input  wire logic        internal_clock_mode,
  // outputs to pads and interrupt logic
  output logic             regulator_en,
  output logic             ps2_pullup_en,
  output logic             open_drain_mode,
  output logic             irq_ps2_mode,
  output logic             shared_irq,
  output logic             bus_reset,
  output logic             token_match,
  output logic [3:0]       token_pid,
  output logic [1:0]       token_endp
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic dp_s;
  logic dm_s;
  logic dm_n_s;
  logic vr_s;
  logic xt_s;

  ups_sync3 u_sync_dp (.pclk(pclk), .presetn(presetn), .din(dplus_in),          .dout(dp_s));
  ups_sync3 u_sync_dm (.pclk(pclk), .presetn(presetn), .din(!dminus_in),        .dout(dm_n_s));
  ups_sync3 u_sync_vr (.pclk(pclk), .presetn(presetn), .din(regulator_pin_in),  .dout(vr_s));
  ups_sync3 u_sync_xt (.pclk(pclk), .presetn(presetn), .din(crystal_input_pin), .dout(xt_s));
  // d- idles high: synchronised inverted so reset gives idle, no false activity
  assign dm_s = !dm_n_s;

  // ****************************************
  // register state
  // ****************************************
  logic [7:0]  statctl;
  logic [7:0]  next_statctl;
  logic [7:0]  devaddr;
  logic [7:0]  next_devaddr;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_access;
  logic        rd_setup;
  logic        activity;
  logic [7:0]  aux_value;
  logic [7:0]  engstat;

  assign wr_access = psel && penable && pwrite && pready;
  assign rd_setup  = psel && !penable;

  // ****************************************
  // line activity and bus reset detect
  // ****************************************
  logic       dp_q;
  logic       dm_q;
  logic [4:0] se0_cnt;
  logic [4:0] next_se0_cnt;
  logic       next_bus_reset;

  assign activity = (dp_q != dp_s) || (dm_q != dm_s) || (!dp_s && !dm_s);

  always_comb begin
    next_se0_cnt   = 5'h00;
    next_bus_reset = 1'b0;
    if (!dp_s && !dm_s) begin
      next_se0_cnt = se0_cnt;
      if (se0_cnt != 5'(`UPS_BUS_RESET_CYC)) begin
        next_se0_cnt = se0_cnt + 5'h01;
      end else begin
        next_bus_reset = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_q      <= 1'b0;
      dm_q      <= 1'b1;
      se0_cnt   <= 5'h00;
      bus_reset <= 1'b0;
    end else begin
      dp_q      <= dp_s;
      dm_q      <= dm_s;
      se0_cnt   <= next_se0_cnt;
      bus_reset <= next_bus_reset;
    end
  end

  // ****************************************
  // token receiver
  // ****************************************
  ups_pkg::ups_rx_state_t rx_state;
  ups_pkg::ups_rx_state_t next_rx_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [4:0]  nbits;
  logic [4:0]  next_nbits;
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [2:0]  ones;
  logic [2:0]  next_ones;
  logic        last_j;
  logic        next_last_j;
  logic [4:0]  crc;
  logic [4:0]  next_crc;
  logic        next_token_match;
  logic        rx_bit;
  logic        sample;
  logic        addr_ok;

  assign sample = (bit_cnt == `UPS_BIT_TIME_CYC);
  // nrzi decode: no transition is a one
  assign rx_bit = (dm_s == last_j);

  // address zero always accepted; own address needs enable
  assign addr_ok = (shreg[14:8] == 7'h00) ||
                   (devaddr[`UPS_DA_ENABLE] && shreg[14:8] == devaddr[6:0]);

  always_comb begin
    next_rx_state    = rx_state;
    next_bit_cnt     = sample ? 4'h0 : bit_cnt + 4'h1;
    next_nbits       = nbits;
    next_shreg       = shreg;
    next_ones        = ones;
    next_last_j      = last_j;
    next_crc         = crc;
    next_token_match = 1'b0;
    case (rx_state)
      ups_pkg::ups_st_idle: begin
        next_bit_cnt = 4'h0;
        next_last_j  = dm_s;
        if (dp_s && !dm_s) begin
          next_rx_state = ups_pkg::ups_st_sync;
          next_nbits    = 5'h00;
        end
      end
      ups_pkg::ups_st_sync: begin
        if (sample) begin
          next_last_j = dm_s;
          next_nbits  = nbits + 5'h01;
          if (nbits == `UPS_SYNC_LAST) begin
            next_rx_state = ups_pkg::ups_st_data;
            next_nbits    = 5'h00;
            next_ones     = 3'h0;
            next_crc      = `UPS_CRC5_INIT;
          end
        end
      end
      ups_pkg::ups_st_data: begin
        if (!dp_s && !dm_s) begin
          next_rx_state = ups_pkg::ups_st_done;
        end else if (sample) begin
          next_last_j = dm_s;
          if (ones == `UPS_STUFF_LIMIT) begin
            next_ones = 3'h0;
          end else begin
            next_ones  = rx_bit ? ones + 3'h1 : 3'h0;
            next_shreg = {rx_bit, shreg[23:1]};
            next_nbits = nbits + 5'h01;
            // checksum over address, endpoint and crc
            if (nbits >= 5'h08) begin
              next_crc = {crc[3:0], 1'b0} ^ ((crc[4] ^ rx_bit) ? `UPS_CRC5_POLY : 5'h00);
            end
          end
        end
      end
      ups_pkg::ups_st_done: begin
        next_rx_state = ups_pkg::ups_st_idle;
        // token type and address check; three endpoints
        if (nbits == 5'h18 && shreg[3:0] == ~shreg[7:4] &&
            crc == `UPS_CRC5_RESID && addr_ok &&
            {shreg[18], shreg[17:15]} < {2'h0, `UPS_ENDPOINTS} &&
            (shreg[3:0] == `UPS_PID_SETUP || shreg[3:0] == `UPS_PID_IN ||
             shreg[3:0] == `UPS_PID_OUT)) begin
          next_token_match = 1'b1;
        end
      end
      default: begin
        next_rx_state = ups_pkg::ups_st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state    <= ups_pkg::ups_st_idle;
      bit_cnt     <= 4'h0;
      nbits       <= 5'h00;
      shreg       <= 24'h000000;
      ones        <= 3'h0;
      last_j      <= 1'b0;
      crc         <= 5'h00;
      token_match <= 1'b0;
      token_pid   <= 4'h0;
      token_endp  <= 2'h0;
    end else begin
      rx_state    <= next_rx_state;
      bit_cnt     <= next_bit_cnt;
      nbits       <= next_nbits;
      shreg       <= next_shreg;
      ones        <= next_ones;
      last_j      <= next_last_j;
      crc         <= next_crc;
      token_match <= next_token_match;
      if (next_token_match) begin
        token_pid  <= shreg[3:0];
        token_endp <= shreg[16:15];
      end
    end
  end

  // ****************************************
  // registers and apb
  // ****************************************
  // auxiliary input port value
  assign aux_value = {2'h0, dp_s, dm_s, 2'h0, xt_s && internal_clock_mode, vr_s};
  assign engstat   = {3'h0, bus_reset, rx_state};

  always_comb begin
    next_statctl = statctl;
    next_devaddr = devaddr;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (wr_access && paddr == `UPS_ADDR_STATCTL) begin
      // reserved bit 4 forced to zero; zero clears activity
      next_statctl = pwdata[7:0] & `UPS_SC_WR_MASK;
      next_statctl[`UPS_SC_ACTIVITY] = statctl[`UPS_SC_ACTIVITY] & pwdata[`UPS_SC_ACTIVITY];
    end
    if (wr_access && paddr == `UPS_ADDR_DEVADDR) begin
      next_devaddr = pwdata[7:0];
    end
    if (activity) begin
      next_statctl[`UPS_SC_ACTIVITY] = 1'b1;
    end
    if (bus_reset) begin
      next_devaddr = `UPS_DA_RESET;
    end
    if (rd_setup) begin
      next_pready = 1'b1;
      case (paddr)
        `UPS_ADDR_AUX:     next_prdata = {24'h000000, aux_value};
        `UPS_ADDR_STATCTL: next_prdata = {24'h000000, statctl};
        `UPS_ADDR_DEVADDR: next_prdata = {24'h000000, devaddr};
        `UPS_ADDR_ENGSTAT: next_prdata = {24'h000000, engstat};
        default: begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      statctl <= `UPS_SC_RESET;
      devaddr <= `UPS_DA_RESET;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      statctl <= next_statctl;
      devaddr <= next_devaddr;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // line drivers
  // ****************************************
  ups_pkg::ups_force_t force_sel;
  logic next_dp_out;
  logic next_dp_oe;
  logic next_dm_out;
  logic next_dm_oe;

  assign force_sel = ups_pkg::ups_force_t'(next_statctl[`UPS_SC_FORCE_MSB:`UPS_SC_FORCE_LSB]);

  always_comb begin
    next_dp_out = 1'b0;
    next_dp_oe  = 1'b0;
    next_dm_out = 1'b0;
    next_dm_oe  = 1'b0;
    case (force_sel)
      // engine control or forced usb states
      ups_pkg::ups_force_none: begin
        next_dp_out = engine_dplus;
        next_dm_out = engine_dminus;
        next_dp_oe  = engine_drive;
        next_dm_oe  = engine_drive;
      end
      ups_pkg::ups_force_k: begin
        next_dp_out = 1'b1;
        next_dp_oe  = 1'b1;
        next_dm_oe  = 1'b1;
      end
      ups_pkg::ups_force_j: begin
        next_dm_out = 1'b1;
        next_dp_oe  = 1'b1;
        next_dm_oe  = 1'b1;
      end
      ups_pkg::ups_force_se0: begin
        next_dp_oe = 1'b1;
        next_dm_oe = 1'b1;
      end
      // ps2 forces; open drain, only low driven
      ups_pkg::ups_force_ps2lo: begin
        next_dp_oe = 1'b1;
        next_dm_oe = 1'b1;
      end
      ups_pkg::ups_force_dmlo: next_dm_oe = 1'b1;
      ups_pkg::ups_force_dplo: next_dp_oe = 1'b1;
      ups_pkg::ups_force_float: begin
        next_dp_oe = 1'b0;
      end
      default: begin
        next_dp_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dplus_out       <= 1'b0;
      dplus_oe        <= 1'b0;
      dminus_out      <= 1'b0;
      dminus_oe       <= 1'b0;
      regulator_en    <= 1'b0;
      ps2_pullup_en   <= 1'b0;
      open_drain_mode <= 1'b0;
      irq_ps2_mode    <= 1'b0;
      shared_irq      <= 1'b0;
    end else begin
      dplus_out       <= next_dp_out;
      dplus_oe        <= next_dp_oe;
      dminus_out      <= next_dm_out;
      dminus_oe       <= next_dm_oe;
      regulator_en    <= next_statctl[`UPS_SC_REGULATOR_PIN_EN];
      ps2_pullup_en   <= next_statctl[`UPS_SC_PU_EN];
      open_drain_mode <= next_statctl[`UPS_SC_OPEN_DRAIN];
      irq_ps2_mode    <= next_statctl[`UPS_SC_IRQ_MODE];
      shared_irq      <= next_statctl[`UPS_SC_IRQ_MODE] ? activity : next_bus_reset;
    end
  end

endmodule : ups_port_ctrl

`default_nettype wire

// *** rtl/ups_defines.svh ***
`ifndef UPS_DEFINES_SVH
`define UPS_DEFINES_SVH

// ****************************************
// register byte addresses
// ****************************************
`define UPS_ADDR_AUX        12'h008
`define UPS_ADDR_STATCTL    12'h07c
`define UPS_ADDR_DEVADDR    12'h040
`define UPS_ADDR_ENGSTAT    12'h100

// ****************************************
// register indices as printed
// ****************************************
`define UPS_IDX_AUX         8'h02
`define UPS_IDX_STATCTL     8'h1f
`define UPS_IDX_DEVADDR     8'h10

// ****************************************
// status and control fields
// ****************************************
`define UPS_SC_FORCE_LSB    0
`define UPS_SC_FORCE_MSB    2
`define UPS_SC_OPEN_DRAIN   2
`define UPS_SC_ACTIVITY     3
`define UPS_SC_IRQ_MODE     5
`define UPS_SC_REGULATOR_PIN_EN      6
`define UPS_SC_PU_EN        7
`define UPS_SC_WR_MASK      8'he7
`define UPS_SC_RESET        8'h00

// ****************************************
// aux port fields
// ****************************************
`define UPS_AUX_REG_PIN     0
`define UPS_AUX_XTAL        1
`define UPS_AUX_DMINUS      4
`define UPS_AUX_DPLUS       5

// ****************************************
// device address fields
// ****************************************
`define UPS_DA_ENABLE       7
`define UPS_DA_RESET        8'h00

// ****************************************
// token pids (4-bit code)
// ****************************************
`define UPS_PID_OUT         4'h1
`define UPS_PID_IN          4'h9
`define UPS_PID_SETUP       4'hd
`define UPS_PID_ACK         4'h2
`define UPS_PID_DATA0       4'h3
`define UPS_PID_NAK         4'ha

// ****************************************
// engine constants
// ****************************************
`define UPS_ENDPOINTS       2'h3
`define UPS_CRC5_INIT       5'h1f
`define UPS_CRC5_RESID      5'h0c
`define UPS_CRC5_POLY       5'h05
`define UPS_STUFF_LIMIT     3'h6
`define UPS_SYNC_LAST       5'h06
`define UPS_BIT_TIME_CYC    4'h6
`define UPS_BUS_RESET_NS    2500
`define UPS_CLK_NS          100
`define UPS_BUS_RESET_CYC   ((`UPS_BUS_RESET_NS + `UPS_CLK_NS - 1) / `UPS_CLK_NS)

`endif

// *** rtl/ups_pkg.sv ***
package ups_pkg;

  // ****************************************
  // forced line states
  // ****************************************
  typedef enum logic [2:0] {
    ups_force_none   = 3'h0,
    ups_force_k      = 3'h1,
    ups_force_j      = 3'h2,
    ups_force_se0    = 3'h3,
    ups_force_ps2lo  = 3'h4,
    ups_force_dmlo   = 3'h5,
    ups_force_dplo   = 3'h6,
    ups_force_float  = 3'h7
  } ups_force_t;

  // ****************************************
  // token receiver states
  // ****************************************
  typedef enum logic [3:0] {
    ups_st_idle = 4'h1,
    ups_st_sync = 4'h2,
    ups_st_data = 4'h4,
    ups_st_done = 4'h8
  } ups_rx_state_t;

endpackage : ups_pkg

// *** rtl/ups_sync3.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// three stage input synchroniser
// ****************************************
module ups_sync3 (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and result
  input  wire logic din,
  output logic      dout
);

  logic [2:0] stage;
  logic       next_dout;

  always_comb begin
    next_dout = dout;
    if (stage[1] == stage[2]) begin
      next_dout = stage[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 3'h0;
      dout  <= 1'b0;
    end else begin
      stage <= {stage[1:0], din};
      dout  <= next_dout;
    end
  end

endmodule : ups_sync3

`default_nettype wire

// *** verification/ups_port_ctrl_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ups_defines.svh"

// ****************************************
// port control checker
// ****************************************
module ups_port_ctrl_monitor (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  // lines and controls
  input  wire logic        dplus_out,
  input  wire logic        dplus_oe,
  input  wire logic        dminus_out,
  input  wire logic        dminus_oe,
  input  wire logic        regulator_en,
  input  wire logic        ps2_pullup_en,
  input  wire logic        open_drain_mode,
  input  wire logic        irq_ps2_mode
);
  logic       wr_sc;
  logic       settled;
  logic [2:0] sc_q;
  logic [2:0] sc_old;
  logic [2:0] next_sc_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign wr_sc   = psel && penable && pready && pwrite && paddr == `UPS_ADDR_STATCTL;
  assign settled = sc_q == sc_old;

  always_comb begin
    next_sc_q = wr_sc ? pwdata[2:0] : sc_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q   <= 3'h0;
      sc_old <= 3'h0;
    end else begin
      sc_q   <= next_sc_q;
      sc_old <= sc_q;
    end
  end

  force_k_a: assert property (settled && sc_q == 3'h1 |-> dplus_oe && dplus_out && dminus_oe && !dminus_out)
    else $error("force k drive wrong");
  force_j_a: assert property (settled && sc_q == 3'h2 |-> dplus_oe && !dplus_out && dminus_oe && dminus_out)
    else $error("force j drive wrong");
  force_se0_a: assert property (settled && sc_q == 3'h3 |-> dplus_oe && !dplus_out && dminus_oe && !dminus_out)
    else $error("force se0 drive wrong");
  ps2_low_a: assert property (settled && sc_q == 3'h4 |-> dplus_oe && !dplus_out && dminus_oe && !dminus_out)
    else $error("ps2 low drive wrong");
  float_both_a: assert property (settled && sc_q == 3'h7 |-> !dplus_oe && !dminus_oe)
    else $error("float drive wrong");
  od_flag_a: assert property (wr_sc |=> open_drain_mode == $past(pwdata[2]))
    else $error("open drain flag wrong");
  reg_en_a: assert property (wr_sc |=> regulator_en == $past(pwdata[6]))
    else $error("regulator enable wrong");
  pullup_en_a: assert property (wr_sc |=> ps2_pullup_en == $past(pwdata[7]))
    else $error("pullup enable wrong");
  irq_mode_a: assert property (wr_sc |=> irq_ps2_mode == $past(pwdata[5]))
    else $error("irq mode wrong");
  reset_clear_a: assert property ($rose(presetn) |-> !regulator_en && !ps2_pullup_en && !irq_ps2_mode)
    else $error("outputs not cleared");

  cover property (settled && sc_q == 3'h1);
  cover property (settled && sc_q == 3'h7);
  cover property (wr_sc && pwdata[6]);
endmodule : ups_port_ctrl_monitor

bind ups_port_ctrl ups_port_ctrl_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .dplus_out(dplus_out), .dplus_oe(dplus_oe),
  .dminus_out(dminus_out), .dminus_oe(dminus_oe), .regulator_en(regulator_en),
  .ps2_pullup_en(ps2_pullup_en), .open_drain_mode(open_drain_mode), .irq_ps2_mode(irq_ps2_mode)
);
`default_nettype wire

// *** verification/ups_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// host side of the data lines
// ****************************************
module ups_host_model (
  // device drivers
  input  wire logic dplus_out,
  input  wire logic dplus_oe,
  input  wire logic dminus_out,
  input  wire logic dminus_oe,
  input  wire logic ps2_pullup_en,
  // host drive request
  input  wire logic host_en,
  input  wire logic host_dp,
  input  wire logic host_dm,
  // resolved lines
  output logic      dplus_line,
  output logic      dminus_line
);
  always_comb begin
    if (dplus_oe) begin
      dplus_line = dplus_out;
    end else if (host_en) begin
      dplus_line = host_dp;
    end else begin
      dplus_line = ps2_pullup_en;
    end
    if (dminus_oe) begin
      dminus_line = dminus_out;
    end else if (host_en) begin
      dminus_line = host_dm;
    end else begin
      dminus_line = 1'b1;
    end
  end
endmodule : ups_host_model
`default_nettype wire

// *** verification/tb_usb_ps2_port_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ups_defines.svh"

module tb_usb_ps2_port_control;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        dplus_in, dminus_in, dplus_out, dplus_oe, dminus_out, dminus_oe;
  logic        engine_drive, engine_dplus, engine_dminus, host_en, host_dp, host_dm;
  logic        regulator_pin_in, crystal_input_pin, internal_clock_mode;
  logic        regulator_en, ps2_pullup_en, open_drain_mode, irq_ps2_mode;
  logic        shared_irq, bus_reset, token_match;
  logic [3:0]  token_pid;
  logic [1:0]  token_endp;
  logic [7:0]  v;
  logic [2:0]  ford [8];
  int          mismatches, compares, i;
  int          tok_cnt = 0;

  ups_port_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dplus_in(dplus_in), .dminus_in(dminus_in), .dplus_out(dplus_out), .dplus_oe(dplus_oe),
    .dminus_out(dminus_out), .dminus_oe(dminus_oe), .engine_drive(engine_drive),
    .engine_dplus(engine_dplus), .engine_dminus(engine_dminus), .regulator_pin_in(regulator_pin_in),
    .crystal_input_pin(crystal_input_pin), .internal_clock_mode(internal_clock_mode),
    .regulator_en(regulator_en), .ps2_pullup_en(ps2_pullup_en), .open_drain_mode(open_drain_mode),
    .irq_ps2_mode(irq_ps2_mode), .shared_irq(shared_irq), .bus_reset(bus_reset),
    .token_match(token_match), .token_pid(token_pid), .token_endp(token_endp));

  ups_host_model u_host (.dplus_out(dplus_out), .dplus_oe(dplus_oe), .dminus_out(dminus_out),
    .dminus_oe(dminus_oe), .ps2_pullup_en(ps2_pullup_en), .host_en(host_en), .host_dp(host_dp),
    .host_dm(host_dm), .dplus_line(dplus_in), .dminus_line(dminus_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (token_match === 1'b1) tok_cnt <= tok_cnt + 1;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] aux_exp(logic dp, logic dm, logic x, logic icm, logic r);
    return {26'h0, dp, dm, 2'b00, x & icm, r};
  endfunction : aux_exp

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, a != `UPS_ADDR_AUX && a != `UPS_ADDR_STATCTL &&
                                  a != `UPS_ADDR_DEVADDR && a != `UPS_ADDR_ENGSTAT});
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task send_token(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
    logic [10:0] d;
    logic [4:0]  c;
    logic [23:0] b;
    logic        one;
    int          k, n1;
    d = {e, a};
    c = `UPS_CRC5_INIT;
    for (k = 0; k < 11; k++) c = {c[3:0], 1'b0} ^ ((c[4] ^ d[k]) ? `UPS_CRC5_POLY : 5'h00);
    c = ~c;
    b = {c[0], c[1], c[2], c[3], c[4], e, a, ~p, p};
    n1 = 0;
    host_en <= 1'b1;
    host_dp <= 1'b0;
    host_dm <= 1'b1;
    repeat (7) @(posedge pclk);
    for (k = 0; k < 32; k++) begin
      one = (k == 7) || (k > 7 && b[k - 8]);
      if (!one) {host_dp, host_dm} <= {host_dm, host_dp};
      repeat (7) @(posedge pclk);
      n1 = (one && k > 7) ? n1 + 1 : 0;
      if (n1 == 6) begin
        {host_dp, host_dm} <= {host_dm, host_dp};
        n1 = 0;
        repeat (7) @(posedge pclk);
      end
    end
    {host_dp, host_dm} <= 2'b00;
    repeat (14) @(posedge pclk);
    host_dm <= 1'b1;
    repeat (7) @(posedge pclk);
    host_en <= 1'b0;
  endtask : send_token

  task do_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  task summarize;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (6000) @(posedge pclk);
    mismatches++;
    summarize;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {engine_drive, engine_dplus, engine_dminus, host_en, host_dp, host_dm} = '0;
    {regulator_pin_in, crystal_input_pin, internal_clock_mode} = '0;
    mismatches = 0;
    compares = 0;
    ford = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};
    i = $urandom(16865);
    do_reset;
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'he0;
      v[2:0] = ford[i];
      apb(1'b1, `UPS_ADDR_STATCTL, {24'h0, v});
      repeat (4) @(posedge pclk);
      apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
      chk(rd & 32'hf7, {24'h0, v});
      chk({29'h0, irq_ps2_mode, regulator_en, ps2_pullup_en}, {29'h0, v[5], v[6], v[7]});
    end
    $display("test force done");
    apb(1'b1, `UPS_ADDR_STATCTL, 32'h0);
    engine_drive <= 1'b1;
    for (i = 0; i < 4; i++) begin
      engine_dplus  <= 1'($urandom);
      engine_dminus <= 1'($urandom);
      repeat (4) @(posedge pclk);
      chk({dplus_oe, dplus_out, dminus_oe, dminus_out}, {1'b1, engine_dplus, 1'b1, engine_dminus});
    end
    engine_drive <= 1'b0;
    repeat (6) @(posedge pclk);
    $display("test engine done");
    apb(1'b1, `UPS_ADDR_STATCTL, 32'h0);
    apb(1'b1, `UPS_ADDR_STATCTL, 32'h08);
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h0);
    host_en <= 1'b1;
    repeat (3) @(posedge pclk);
    host_en <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h08);
    apb(1'b1, `UPS_ADDR_STATCTL, 32'h08);
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h08);
    apb(1'b1, `UPS_ADDR_STATCTL, 32'h0);
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h0);
    $display("test activity done");
    for (i = 0; i < 8; i++) begin
      host_en <= 1'b1;
      host_dp <= 1'($urandom);
      host_dm <= 1'($urandom);
      regulator_pin_in    <= 1'($urandom);
      crystal_input_pin   <= 1'($urandom);
      internal_clock_mode <= 1'($urandom);
      repeat (6) @(posedge pclk);
      apb(1'b0, `UPS_ADDR_AUX, 32'h0);
      chk(rd, aux_exp(host_dp, host_dm, crystal_input_pin, internal_clock_mode, regulator_pin_in));
    end
    host_en <= 1'b0;
    $display("test aux done");
    apb(1'b1, `UPS_ADDR_DEVADDR, 32'h85);
    apb(1'b0, `UPS_ADDR_DEVADDR, 32'h0);
    chk(rd, 32'h85);
    host_dp <= 1'b0;
    host_dm <= 1'b0;
    host_en <= 1'b1;
    repeat (40) @(posedge pclk);
    chk({30'h0, bus_reset, shared_irq}, 32'h3);
    host_en <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, `UPS_ADDR_DEVADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test bus reset done");
    send_token(`UPS_PID_SETUP, 7'h00, 4'h0);
    chk({tok_cnt[7:0], token_pid, 2'h0, token_endp}, {8'h01, `UPS_PID_SETUP, 4'h0});
    send_token(`UPS_PID_IN, 7'h05, 4'h1);
    chk({tok_cnt[7:0], token_pid, 2'h0, token_endp}, {8'h01, `UPS_PID_SETUP, 4'h0});
    apb(1'b1, `UPS_ADDR_DEVADDR, 32'h85);
    v = 8'($urandom % 3);
    send_token(`UPS_PID_OUT, 7'h05, v[3:0]);
    chk({tok_cnt[7:0], token_pid, 2'h0, token_endp}, {8'h02, `UPS_PID_OUT, 2'h0, v[1:0]});
    send_token(`UPS_PID_IN, 7'h05, 4'h3);
    chk({tok_cnt[7:0], token_pid, 2'h0, token_endp}, {8'h02, `UPS_PID_OUT, 2'h0, v[1:0]});
    $display("test token done");
    apb(1'b1, `UPS_ADDR_STATCTL, 32'he3);
    do_reset;
    apb(1'b0, `UPS_ADDR_STATCTL, 32'h0);
    chk(rd, 32'h0);
    chk({29'h0, regulator_en, ps2_pullup_en, open_drain_mode}, 32'h0);
    $display("test second reset done");
    summarize;
  end
endmodule : tb_usb_ps2_port_control
`default_nettype wire
